// [rtl/usb_ep_decide.sv]
// Purpose: Token response and automatic mode change for one endpoint
// Assumes: Inputs stable in the cycle a decision is taken
// Notes:   Purely combinational
`default_nettype none
module usb_ep_decide (
	// Endpoint state
	input  wire logic [3:0]           i_mode,
	input  wire logic                 i_stall,
	input  wire logic                 i_is_ctrl,
	// Transaction
	input  wire usb_ep_pkg::pid_e     i_pid,
	input  wire usb_ep_pkg::rx_info_s i_rx,
	// Decision
	output usb_ep_pkg::decide_s       o_dec
);

	logic check_ok;

	always_comb begin
		check_ok        = i_rx.crc_ok && (i_rx.len == 6'h00) && i_rx.tog;
		o_dec.hs        = usb_ep_pkg::HS_NONE;
		o_dec.next_mode = i_mode;
		o_dec.intr      = 1'b0;
		o_dec.take_data = 1'b0;
		case (i_pid)
			usb_ep_pkg::PID_SETUP: begin
				if (usb_ep_pkg::accepts_setup(i_mode)) begin
					o_dec.take_data = 1'b1;
					o_dec.intr      = 1'b1;
					if (i_rx.crc_ok) begin
						o_dec.hs = usb_ep_pkg::HS_ACK;
						if (i_is_ctrl)
							o_dec.next_mode = usb_ep_pkg::MODE_NAK_INOUT;
					end
				end
			end
			usb_ep_pkg::PID_IN: begin
				case (i_mode)
					usb_ep_pkg::MODE_NAK_INOUT, usb_ep_pkg::MODE_NAK_IN,
					usb_ep_pkg::MODE_NAK_IN_STOUT:
						o_dec.hs = usb_ep_pkg::HS_NAK;
					usb_ep_pkg::MODE_STATUS_OUT, usb_ep_pkg::MODE_STALL_INOUT:
						o_dec.hs = usb_ep_pkg::HS_STALL;
					usb_ep_pkg::MODE_STATUS_IN, usb_ep_pkg::MODE_NAK_OUT_STIN,
					usb_ep_pkg::MODE_ACK_OUT_STIN:
						o_dec.hs = usb_ep_pkg::HS_TX_ZERO;
					usb_ep_pkg::MODE_ISO_IN:
						o_dec.hs = usb_ep_pkg::HS_TX_COUNT;
					usb_ep_pkg::MODE_ACK_IN_STOUT: begin
						o_dec.hs        = usb_ep_pkg::HS_TX_COUNT;
						o_dec.next_mode = usb_ep_pkg::MODE_NAK_IN_STOUT;
					end
					usb_ep_pkg::MODE_ACK_IN: begin
						if (i_stall && !i_is_ctrl) begin
							o_dec.hs = usb_ep_pkg::HS_STALL;
						end else begin
							o_dec.hs        = usb_ep_pkg::HS_TX_COUNT;
							o_dec.next_mode = usb_ep_pkg::MODE_NAK_IN;
						end
					end
					default: o_dec.hs = usb_ep_pkg::HS_NONE;
				endcase
				o_dec.intr = (o_dec.hs != usb_ep_pkg::HS_NONE);
			end
			usb_ep_pkg::PID_OUT: begin
				if (!i_rx.crc_ok) begin
					// Corrupted buffer still reports unless the endpoint is disabled, but gets no handshake
					o_dec.intr      = (i_mode != usb_ep_pkg::MODE_DISABLE);
					o_dec.take_data = o_dec.intr;
				end else begin
					case (i_mode)
						usb_ep_pkg::MODE_NAK_INOUT, usb_ep_pkg::MODE_NAK_OUT,
						usb_ep_pkg::MODE_NAK_OUT_STIN:
							o_dec.hs = usb_ep_pkg::HS_NAK;
						usb_ep_pkg::MODE_STALL_INOUT, usb_ep_pkg::MODE_STATUS_IN:
							o_dec.hs = usb_ep_pkg::HS_STALL;
						usb_ep_pkg::MODE_ISO_OUT:
							o_dec.take_data = 1'b1;
						usb_ep_pkg::MODE_ACK_OUT: begin
							if (i_stall && !i_is_ctrl) begin
								o_dec.hs = usb_ep_pkg::HS_STALL;
							end else begin
								o_dec.hs        = usb_ep_pkg::HS_ACK;
								o_dec.take_data = 1'b1;
								o_dec.next_mode = usb_ep_pkg::MODE_NAK_OUT;
							end
						end
						usb_ep_pkg::MODE_ACK_OUT_STIN: begin
							o_dec.hs        = usb_ep_pkg::HS_ACK;
							o_dec.take_data = 1'b1;
							o_dec.next_mode = usb_ep_pkg::MODE_NAK_OUT_STIN;
						end
						usb_ep_pkg::MODE_STATUS_OUT, usb_ep_pkg::MODE_NAK_IN_STOUT,
						usb_ep_pkg::MODE_ACK_IN_STOUT: begin
							o_dec.hs = check_ok ? usb_ep_pkg::HS_ACK
							                    : usb_ep_pkg::HS_STALL;
							o_dec.take_data = check_ok;
							if (check_ok && i_mode == usb_ep_pkg::MODE_ACK_IN_STOUT)
								o_dec.next_mode = usb_ep_pkg::MODE_NAK_IN_STOUT;
						end
						default: o_dec.hs = usb_ep_pkg::HS_NONE;
					endcase
					o_dec.intr = o_dec.take_data || (o_dec.hs != usb_ep_pkg::HS_NONE);
				end
			end
			default: o_dec.hs = usb_ep_pkg::HS_NONE;
		endcase
	end

endmodule // usb_ep_decide
`default_nettype wire

// [rtl/usb_ep_mode_lock.sv]
// Purpose: Endpoint handshake choice, mode/count update and write interlock
// Assumes: Engine events are single-cycle pulses on the same clock
// Notes:   Registers reached over Avalon-MM, one access per two cycles
`default_nettype none
module usb_ep_mode_lock (
	// Clock and reset
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_arst_n,
	// Avalon-MM register slave
	input  wire logic [7:0]           i_avs_address,
	input  wire logic                 i_avs_read,
	input  wire logic                 i_avs_write,
	input  wire logic [31:0]          i_avs_writedata,
	input  wire logic [3:0]           i_avs_byteenable,
	output logic [31:0]               o_avs_readdata,
	output logic                      o_avs_waitrequest,
	// Events from the bus protocol engine
	input  wire logic                 i_tok_valid,
	input  wire usb_ep_pkg::pid_e     i_tok_pid,
	input  wire logic [2:0]           i_tok_ep,
	input  wire logic                 i_rx_start,
	input  wire logic                 i_rx_done,
	input  wire usb_ep_pkg::rx_info_s i_rx_info,
	input  wire logic                 i_host_ack,
	input  wire logic                 i_host_timeout,
	// Handshake choice to the bus protocol engine
	output logic                      o_hs_valid,
	output usb_ep_pkg::hs_e           o_hs,
	output logic [3:0]                o_tx_len,
	// Endpoint interrupt flags
	output logic [4:0]                o_ep_intr
);

	localparam int N = usb_ep_pkg::NUM_EP;

	typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_IN_WAIT} st_e;

	logic                rst_n;
	st_e                 st_r;
	usb_ep_pkg::pid_e    pid_r;
	logic [2:0]          ep_r;
	usb_ep_pkg::decide_s dec;
	usb_ep_pkg::decide_s dec_in_r;
	logic [6:0]          mode_lo_r [N];
	logic [N-1:0]        mode_hi_r;
	logic [7:0]          cnt_r [N];
	logic [N-1:0]        intr_r;
	logic                mode_lock_r;
	logic                cnt_lock_r;
	logic                setup_force_r;
	logic                wreq_r;

	usb_ep_pkg::pid_e    cur_pid;
	logic [2:0]          cur_ep;
	logic [2:0]          sel_ep;
	logic                cur_ep_ok;
	logic                commit;
	logic                commit_ack;
	logic [2:0]          commit_ep;
	usb_ep_pkg::pid_e    commit_pid;
	usb_ep_pkg::decide_s commit_dec;
	logic                setup_pt;
	logic                setup_end;
	logic                lock_mode_set;
	logic                lock_cnt_set;
	logic                wr_go;
	logic                rd_smp;
	logic [N-1:0]        wr_mode;
	logic [N-1:0]        wr_cnt;
	logic [N-1:0]        rd_mode;
	logic [N-1:0]        rd_cnt;
	logic                rd_intr;
	logic [31:0]         rd_mux;

	usb_ep_rst_sync u_rst_sync (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.o_rst_n   (rst_n)
	);

	// Decision is taken on the live token in idle, else on the latched one
	assign cur_pid   = (st_r == ST_IDLE) ? i_tok_pid : pid_r;
	assign cur_ep    = (st_r == ST_IDLE) ? i_tok_ep : ep_r;
	assign cur_ep_ok = (cur_ep < 3'(N));
	assign sel_ep    = cur_ep_ok ? cur_ep : 3'h0;

	usb_ep_decide u_decide (
		.i_mode    (mode_lo_r[sel_ep][3:0]),
		.i_stall   (mode_hi_r[sel_ep]),
		.i_is_ctrl (usb_ep_pkg::CTRL_EP_MASK[sel_ep]),
		.i_pid     (cur_pid),
		.i_rx      (i_rx_info),
		.o_dec     (dec)
	);

	// Commit point: the moment registers, flags and locks change
	always_comb begin
		commit     = 1'b0;
		commit_ack = 1'b0;
		commit_ep  = ep_r;
		commit_pid = pid_r;
		commit_dec = dec;
		case (st_r)
			ST_IDLE: begin
				if (i_tok_valid && cur_ep_ok && i_tok_pid == usb_ep_pkg::PID_IN &&
				    (dec.hs == usb_ep_pkg::HS_NAK ||
				     dec.hs == usb_ep_pkg::HS_STALL)) begin
					commit     = 1'b1;
					commit_ep  = i_tok_ep;
					commit_pid = usb_ep_pkg::PID_IN;
				end
			end
			ST_RX: begin
				commit     = i_rx_done && dec.intr;
				commit_ack = (dec.hs == usb_ep_pkg::HS_ACK);
			end
			ST_IN_WAIT: begin
				commit     = i_host_ack;
				commit_ack = 1'b1;
				commit_dec = dec_in_r;
			end
			default: commit = 1'b0;
		endcase
	end

	assign setup_pt  = (st_r == ST_RX) && i_rx_start && (ep_r == 3'h0) &&
	                   (pid_r == usb_ep_pkg::PID_SETUP) &&
	                   usb_ep_pkg::accepts_setup(mode_lo_r[0][3:0]);
	assign setup_end = (st_r == ST_RX) && i_rx_done && (ep_r == 3'h0) &&
	                   (pid_r == usb_ep_pkg::PID_OUT);
	assign lock_mode_set = commit && (commit_ep == 3'h0);
	assign lock_cnt_set  = lock_mode_set && commit_dec.take_data;

	// Transaction sequencing
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r     <= ST_IDLE;
			pid_r    <= usb_ep_pkg::PID_SETUP;
			ep_r     <= 3'h0;
			dec_in_r <= '0;
		end else begin
			case (st_r)
				ST_IDLE: begin
					if (i_tok_valid && cur_ep_ok) begin
						pid_r    <= i_tok_pid;
						ep_r     <= i_tok_ep;
						dec_in_r <= dec;
						if (i_tok_pid != usb_ep_pkg::PID_IN)
							st_r <= ST_RX;
						else if (dec.hs == usb_ep_pkg::HS_TX_COUNT ||
						         dec.hs == usb_ep_pkg::HS_TX_ZERO)
							st_r <= ST_IN_WAIT;
					end
				end
				ST_RX:      if (i_rx_done) st_r <= ST_IDLE;
				ST_IN_WAIT: if (i_host_ack || i_host_timeout) st_r <= ST_IDLE;
				default:    st_r <= ST_IDLE;
			endcase
		end
	end

	// Handshake choice to the engine
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_hs_valid <= 1'b0;
			o_hs       <= usb_ep_pkg::HS_NONE;
			o_tx_len   <= 4'h0;
		end else begin
			o_hs_valid <= ((st_r == ST_IDLE) && i_tok_valid && cur_ep_ok &&
			               i_tok_pid == usb_ep_pkg::PID_IN) ||
			              ((st_r == ST_RX) && i_rx_done);
			o_hs       <= dec.hs;
			o_tx_len   <= (dec.hs == usb_ep_pkg::HS_TX_COUNT) ?
			              cnt_r[sel_ep][3:0] : 4'h0;
		end
	end

	// Bus slave: one wait cycle, then the access completes
	assign wr_go   = i_avs_write && !wreq_r && i_avs_byteenable[0];
	assign rd_smp  = i_avs_read && wreq_r;
	assign rd_intr = (i_avs_address == usb_ep_pkg::REG_INTR);

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n)
			wreq_r <= 1'b1;
		else
			wreq_r <= !((i_avs_read || i_avs_write) && wreq_r);
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (rd_intr)
			rd_mux = {27'h0, intr_r};
		for (int k = 0; k < N; k++) begin
			if (rd_mode[k])
				rd_mux = {24'h0, mode_hi_r[k], mode_lo_r[k]};
			if (rd_cnt[k])
				rd_mux = {24'h0, cnt_r[k]};
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n)
			o_avs_readdata <= 32'h0000_0000;
		else if (rd_smp)
			o_avs_readdata <= rd_mux;
	end

	assign o_avs_waitrequest = wreq_r;
	assign o_ep_intr         = intr_r;

	// Endpoint 0 write interlock, a new lock wins over a read
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_lock_r <= 1'b0;
			cnt_lock_r  <= 1'b0;
		end else begin
			if (lock_mode_set)
				mode_lock_r <= 1'b1;
			else if (rd_smp && rd_mode[0])
				mode_lock_r <= 1'b0;
			if (lock_cnt_set)
				cnt_lock_r <= 1'b1;
			else if (rd_smp && rd_cnt[0])
				cnt_lock_r <= 1'b0;
		end
	end

	// Setup flag of endpoint 0, engine set wins over CPU clear
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			setup_force_r <= 1'b0;
			mode_hi_r[0]  <= usb_ep_pkg::MODE_RESET[7];
		end else begin
			if (setup_pt)
				setup_force_r <= 1'b1;
			else if (setup_end)
				setup_force_r <= 1'b0;
			if (setup_pt)
				mode_hi_r[0] <= 1'b1;
			else if (wr_mode[0] && !setup_force_r)
				mode_hi_r[0] <= 1'b0;
		end
	end

	for (genvar g = 0; g < N; g++) begin : g_ep
		localparam logic [7:0] A_MODE = 8'(usb_ep_pkg::REG_MODE_BASE +
		                                   g * usb_ep_pkg::REG_EP_STRIDE);
		localparam logic [7:0] A_CNT  = 8'(usb_ep_pkg::REG_CNT_BASE +
		                                   g * usb_ep_pkg::REG_EP_STRIDE);
		localparam bit         IS_EP0 = (g == 0);
		logic hit;
		logic set_intr;

		assign rd_mode[g] = (i_avs_address == A_MODE);
		assign rd_cnt[g]  = (i_avs_address == A_CNT);
		assign wr_mode[g] = wr_go && rd_mode[g];
		assign wr_cnt[g]  = wr_go && rd_cnt[g];
		assign hit        = commit && (commit_ep == 3'(g));
		assign set_intr   = hit && commit_dec.intr;

		// Mode bits 6:0; only endpoint 0 is locked against writes
		always_ff @(posedge i_clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				mode_lo_r[g] <= usb_ep_pkg::MODE_RESET[6:0];
			end else if (hit) begin
				if (commit_ack) begin
					mode_lo_r[g][3:0] <= commit_dec.next_mode;
					mode_lo_r[g][usb_ep_pkg::MODE_ACK_BIT] <= 1'b1;
				end
				if (IS_EP0 && commit_pid == usb_ep_pkg::PID_IN)
					mode_lo_r[g][usb_ep_pkg::MODE_IN_BIT] <= 1'b1;
				if (IS_EP0 && commit_pid == usb_ep_pkg::PID_OUT)
					mode_lo_r[g][usb_ep_pkg::MODE_OUT_BIT] <= 1'b1;
			end else if (wr_mode[g] && !(IS_EP0 && mode_lock_r)) begin
				mode_lo_r[g] <= i_avs_writedata[6:0];
			end
		end

		// Count register: toggle, data valid, received length plus CRC
		always_ff @(posedge i_clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				cnt_r[g] <= usb_ep_pkg::CNT_RESET;
			end else if (hit && commit_dec.take_data) begin
				cnt_r[g] <= {i_rx_info.tog, i_rx_info.crc_ok,
				             6'(i_rx_info.len + usb_ep_pkg::CRC_BYTES)};
			end else if (wr_cnt[g] && !(IS_EP0 && cnt_lock_r)) begin
				cnt_r[g] <= i_avs_writedata[7:0];
			end
		end

		// Interrupt flag, write one to clear, a new event wins
		always_ff @(posedge i_clk_sys or negedge rst_n) begin
			if (!rst_n)
				intr_r[g] <= 1'b0;
			else if (set_intr)
				intr_r[g] <= 1'b1;
			else if (wr_go && rd_intr && i_avs_writedata[g])
				intr_r[g] <= 1'b0;
		end

		// Stall flag of non-control endpoints
		if (!IS_EP0) begin : g_stall
			always_ff @(posedge i_clk_sys or negedge rst_n) begin
				if (!rst_n)
					mode_hi_r[g] <= usb_ep_pkg::MODE_RESET[7];
				else if (wr_mode[g])
					mode_hi_r[g] <= i_avs_writedata[7];
			end
		end
	end

endmodule // usb_ep_mode_lock
`default_nettype wire

// [rtl/usb_ep_pkg.sv]
// Purpose: Shared constants and types for the endpoint mode and lock logic
// Assumes: Five endpoints, endpoint 0 is the control endpoint
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave
`default_nettype none
package usb_ep_pkg;

	localparam int          NUM_EP       = 5;
	localparam logic [4:0]  CTRL_EP_MASK = 5'h01;

	// Mode codes held in the low nibble of each mode register
	localparam logic [3:0] MODE_DISABLE      = 4'h0;
	localparam logic [3:0] MODE_NAK_INOUT    = 4'h1;
	localparam logic [3:0] MODE_STATUS_OUT   = 4'h2;
	localparam logic [3:0] MODE_STALL_INOUT  = 4'h3;
	localparam logic [3:0] MODE_IGNORE_INOUT = 4'h4;
	localparam logic [3:0] MODE_ISO_OUT      = 4'h5;
	localparam logic [3:0] MODE_STATUS_IN    = 4'h6;
	localparam logic [3:0] MODE_ISO_IN       = 4'h7;
	localparam logic [3:0] MODE_NAK_OUT      = 4'h8;
	localparam logic [3:0] MODE_ACK_OUT      = 4'h9;
	localparam logic [3:0] MODE_NAK_OUT_STIN = 4'ha;
	localparam logic [3:0] MODE_ACK_OUT_STIN = 4'hb;
	localparam logic [3:0] MODE_NAK_IN       = 4'hc;
	localparam logic [3:0] MODE_ACK_IN       = 4'hd;
	localparam logic [3:0] MODE_NAK_IN_STOUT = 4'he;
	localparam logic [3:0] MODE_ACK_IN_STOUT = 4'hf;

	// Mode register fields
	localparam int MODE_ACK_BIT = 4;
	localparam int MODE_OUT_BIT = 5;
	localparam int MODE_IN_BIT  = 6;
	// Count register fields
	localparam int CNT_TOG_BIT  = 7;
	localparam int CNT_DVAL_BIT = 6;

	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CNT_RESET  = 8'h00;
	localparam logic [5:0] CRC_BYTES  = 6'h02;

	// Register map
	localparam logic [7:0] REG_MODE_BASE = 8'h00;
	localparam logic [7:0] REG_CNT_BASE  = 8'h04;
	localparam logic [7:0] REG_EP_STRIDE = 8'h08;
	localparam logic [7:0] REG_INTR      = 8'h28;

	typedef enum logic [1:0] {PID_SETUP, PID_IN, PID_OUT} pid_e;
	typedef enum logic [2:0] {
		HS_NONE, HS_ACK, HS_NAK, HS_STALL, HS_TX_COUNT, HS_TX_ZERO
	} hs_e;

	typedef struct packed {
		logic [5:0] len;
		logic       tog;
		logic       crc_ok;
	} rx_info_s;

	typedef struct packed {
		hs_e        hs;
		logic [3:0] next_mode;
		logic       intr;
		logic       take_data;
	} decide_s;

	function automatic logic accepts_setup(input logic [3:0] m);
		case (m)
			MODE_NAK_INOUT, MODE_STATUS_OUT, MODE_STALL_INOUT,
			MODE_IGNORE_INOUT, MODE_STATUS_IN, MODE_NAK_OUT_STIN,
			MODE_ACK_OUT_STIN, MODE_NAK_IN_STOUT,
			MODE_ACK_IN_STOUT: accepts_setup = 1'b1;
			default:           accepts_setup = 1'b0;
		endcase
	endfunction

endpackage
`default_nettype wire

// [rtl/usb_ep_rst_sync.sv]
// Purpose: Release of the asynchronous reset through two flip-flops
// Assumes: Reset is active low
// Notes:   Assertion is immediate, release follows two clock edges
`default_nettype none
module usb_ep_rst_sync (
	// Clock and raw reset
	input  wire logic i_clk_sys,
	input  wire logic i_arst_n,
	// Synchronised reset
	output logic      o_rst_n
);

	logic meta_r;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_r  <= 1'b0;
			o_rst_n <= 1'b0;
		end else begin
			meta_r  <= 1'b1;
			o_rst_n <= meta_r;
		end
	end

endmodule // usb_ep_rst_sync
`default_nettype wire

// [testbench/usb_endpoint_mode_lock_logic_bench.sv]
// Purpose: Self-checking bench for the endpoint mode and lock logic
// Assumes: Firmware reads an endpoint 0 register before writing it
// Notes:   Handshakes compared with a table model per SETUP/IN/OUT
`default_nettype none
module usb_endpoint_mode_lock_logic_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                      clk = 1'b0;
	logic                      arst_n = 1'b0;
	logic [7:0]                av_addr = 8'h00;
	logic                      av_rd = 1'b0;
	logic                      av_wr = 1'b0;
	logic [31:0]               av_wdata = 32'h0;
	logic [3:0]                av_be = 4'hf;
	logic [31:0]               av_rdata;
	logic                      av_wait;
	wire logic                 tv, rxs, rxd, ha, ht;
	wire usb_ep_pkg::pid_e     tp;
	wire logic [2:0]           te;
	wire usb_ep_pkg::rx_info_s ri;
	logic                      hs_v;
	usb_ep_pkg::hs_e           hs;
	logic [3:0]                tx_len, seen_len;
	logic [4:0]                intr;
	logic [2:0]                seen_hs;
	int                        errors = 0, compares = 0;
	// hs_e ordinals for SETUP, IN, OUT; 6 marks a checked OUT
	string tbl [16] = '{"000", "122", "136", "133", "100", "000", "153",
		"040", "002", "001", "152", "151", "020", "040", "126", "146"};
	usb_ep_mode_lock dut_u (
		.i_clk_sys(clk), .i_arst_n(arst_n), .i_avs_address(av_addr),
		.i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
		.i_avs_byteenable(av_be), .o_avs_readdata(av_rdata),
		.o_avs_waitrequest(av_wait), .i_tok_valid(tv), .i_tok_pid(tp),
		.i_tok_ep(te), .i_rx_start(rxs), .i_rx_done(rxd), .i_rx_info(ri),
		.i_host_ack(ha), .i_host_timeout(ht), .o_hs_valid(hs_v), .o_hs(hs),
		.o_tx_len(tx_len), .o_ep_intr(intr));
	usb_ep_host_model host_u (
		.i_clk_sys(clk), .o_tok_valid(tv), .o_tok_pid(tp), .o_tok_ep(te),
		.o_rx_start(rxs), .o_rx_done(rxd), .o_rx_info(ri), .o_host_ack(ha),
		.o_host_timeout(ht));
	always #20 clk = ~clk;
	always @(posedge clk)
		if (hs_v === 1'b1) begin
			seen_hs = hs;
			seen_len = tx_len;
		end
	function automatic logic [7:0] ra(int ep, int k);
		return 8'(ep) * usb_ep_pkg::REG_EP_STRIDE +
			(k ? usb_ep_pkg::REG_CNT_BASE : usb_ep_pkg::REG_MODE_BASE);
	endfunction
	function automatic int exp_hs(int m, p, l, t, c, s);
		int k = tbl[m][p] - "0";
		if (p != 1 && !c) return 0;
		if (s && (k == 4 || (k == 1 && p == 2))) return 3;
		if (k == 6) return (l == 0 && t) ? 1 : 3;
		return k;
	endfunction
	task automatic chk(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		av_addr  <= a;
		av_wr    <= w;
		av_rd    <= !w;
		av_wdata <= d;
		do @(posedge clk); while (av_wait !== 1'b0);
		q = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		bus(1'b1, a, d, q);
	endtask
	task automatic txn(input int p, ep, l, t, c, mid);
		logic [31:0] q;
		seen_hs = 3'h0;
		seen_len = 4'h0;
		host_u.tok(usb_ep_pkg::pid_e'(p), 3'(ep));
		if (mid) bus(1'b0, ra(0, 0), 32'h0, q);
		if (p != 1) host_u.data('{6'(l), 1'(t), 1'(c)}, $urandom % 2);
		repeat (3) @(posedge clk);
	endtask
	task automatic end_sim();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_sim();
	end
	initial begin
		int ep, s, l, t, c, ok, e, nm;
		logic [31:0] v;
		logic [7:0] cv;
		void'($urandom(32'h19d5));
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			bus(1'b0, ra(i / 2, i % 2), 32'h0, v);
			chk("reset", v, 32'h0);
		end
		bus(1'b0, 8'h2c, 32'h0, v);
		chk("unmapped", v, 32'h0);
		av_be <= 4'he;
		bus(1'b1, ra(1, 0), 32'h0f, v);
		av_be <= 4'hf;
		bus(1'b0, ra(1, 0), 32'h0, v);
		chk("no_be", v, 32'h0);
		// Setup flag forced until a later OUT completes
		wr_reg(ra(0, 0), 32'h01);
		txn(0, 0, 8, 0, 1, 0);
		chk("setup_hs", 32'(seen_hs), 1);
		bus(1'b0, ra(0, 0), 32'h0, v);
		chk("setup_bit", v[7], 1);
		chk("setup_mode", v[3:0], 1);
		bus(1'b1, ra(0, 0), 32'h01, v);
		bus(1'b0, ra(0, 0), 32'h0, v);
		chk("setup_held", v[7], 1);
		txn(2, 0, 0, 1, 1, 0);
		chk("nak_out", 32'(seen_hs), 2);
		wr_reg(ra(0, 0), 32'h01);
		bus(1'b0, ra(0, 0), 32'h0, v);
		chk("setup_clr", v[7], 0);
		// Read before the commit must leave the lock in place
		wr_reg(ra(0, 0), 32'h0b);
		txn(2, 0, 0, 1, 1, 1);
		chk("ack_out", 32'(seen_hs), 1);
		bus(1'b1, ra(0, 0), 32'h0f, v);
		bus(1'b0, ra(0, 0), 32'h0, v);
		chk("locked", v[3:0], 4'ha);
		wr_reg(ra(0, 0), 32'h0f);
		bus(1'b0, ra(0, 0), 32'h0, v);
		chk("unlocked", v[3:0], 4'hf);
		for (int m = 0; m < 16; m++)
			for (int p = 0; p < 3; p++) begin
				ep = (p == 0) ? 0 : 1 + $urandom % 4;
				s = ((m == 9 || m == 13) && p != 0) ? $urandom % 2 : 0;
				l = $urandom % 2;
				t = $urandom % 2;
				ok = $urandom % 2;
				c = (p != 2) || ($urandom % 4 != 0);
				cv = 8'($urandom);
				wr_reg(ra(ep, 0), {24'h0, 1'(s), 3'h0, 4'(m)});
				wr_reg(ra(ep, 1), {24'h0, cv});
				wr_reg(usb_ep_pkg::REG_INTR, 32'h1f);
				// Clear lands at the completing edge; look one edge later
				@(posedge clk);
				chk("intr_clr", intr, 0);
				e = exp_hs(m, p, l, t, c, s);
				txn(p, ep, l, t, c, 0);
				chk("hs", 32'(seen_hs), e);
				chk("tx_len", seen_len, e == 4 ? cv[3:0] : 0);
				if (e > 3) host_u.reply(1'(ok), $urandom % 3);
				nm = m;
				if (e == 1 && p == 0) nm = 1;
				if (e == 1 && p == 2 && m inside {9, 11, 15}) nm = m - 1;
				if (ok && e == 4 && m inside {13, 15}) nm = m - 1;
				bus(1'b0, ra(ep, 0), 32'h0, v);
				chk("mode", v[3:0], nm);
				if (e == 1 || (ok && e > 3)) chk("intr", intr[ep], 1);
			end
		txn(1, 5 + $urandom % 3, 0, 0, 1, 0);
		chk("bad_ep", 32'(seen_hs), 0);
		end_sim();
	end
endmodule // usb_endpoint_mode_lock_logic_bench
`default_nettype wire

// [testbench/usb_ep_host_model.sv]
// Purpose: Host side of the engine link: tokens, data packets, IN replies
// Assumes: Caller resumes just after a rising edge
// Notes:   Released endpoint and packet info lines show the inverse of their last value
`default_nettype none
module usb_ep_host_model (
	// Clock
	input  wire logic                 i_clk_sys,
	// Engine events
	output var logic                  o_tok_valid,
	output var usb_ep_pkg::pid_e      o_tok_pid,
	output var logic [2:0]            o_tok_ep,
	output var logic                  o_rx_start,
	output var logic                  o_rx_done,
	output var usb_ep_pkg::rx_info_s  o_rx_info,
	output var logic                  o_host_ack,
	output var logic                  o_host_timeout
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{o_tok_valid, o_rx_start, o_rx_done} = 3'h0;
		{o_host_ack, o_host_timeout, o_tok_ep} = 5'h00;
		o_tok_pid = usb_ep_pkg::PID_SETUP;
		o_rx_info = 8'h00;
	end
	task automatic tok(input usb_ep_pkg::pid_e p, input logic [2:0] ep);
		@(posedge i_clk_sys);
		o_tok_valid <= 1'b1;
		o_tok_pid   <= p;
		o_tok_ep    <= ep;
		@(posedge i_clk_sys);
		o_tok_valid <= 1'b0;
		o_tok_ep    <= ~ep;
	endtask
	// Data toggle and length come from the caller unchanged
	task automatic data(input usb_ep_pkg::rx_info_s r, input int dly);
		repeat (dly) @(posedge i_clk_sys);
		o_rx_start <= 1'b1;
		@(posedge i_clk_sys);
		o_rx_start <= 1'b0;
		@(posedge i_clk_sys);
		o_rx_done <= 1'b1;
		o_rx_info <= r;
		@(posedge i_clk_sys);
		o_rx_done <= 1'b0;
		o_rx_info <= ~r;
	endtask
	task automatic reply(input logic ok, input int dly);
		repeat (dly + 1) @(posedge i_clk_sys);
		o_host_ack     <= ok;
		o_host_timeout <= !ok;
		@(posedge i_clk_sys);
		o_host_ack     <= 1'b0;
		o_host_timeout <= 1'b0;
	endtask
endmodule // usb_ep_host_model
`default_nettype wire

// [testbench/usb_ep_mode_lock_properties.sv]
// Purpose: Port-level assertions for the endpoint mode and lock logic
// Assumes: One clock, reset active low
// Notes:   Bound into the top module below
`default_nettype none
module usb_ep_mode_lock_properties (
	// Clock and reset
	input wire logic                 i_clk_sys,
	input wire logic                 i_arst_n,
	// Register bus
	input wire logic [7:0]           i_avs_address,
	input wire logic                 i_avs_read,
	input wire logic                 i_avs_write,
	input wire logic                 o_avs_waitrequest,
	// Engine link
	input wire logic                 i_tok_valid,
	input wire logic [2:0]           i_tok_ep,
	input wire logic                 i_rx_done,
	input wire usb_ep_pkg::rx_info_s i_rx_info,
	input wire logic                 i_host_ack,
	input wire logic                 o_hs_valid,
	input wire usb_ep_pkg::hs_e      o_hs,
	input wire logic [3:0]           o_tx_len,
	input wire logic [4:0]           o_ep_intr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	wait_low_a:
		assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
			|=> !o_avs_waitrequest) else $error("bus answer late");
	wait_pulse_a:
		assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
			else $error("wait low too long");
	hs_pulse_a:
		assert property (o_hs_valid |=> !o_hs_valid)
			else $error("handshake valid too long");
	hs_cause_a:
		assert property (o_hs_valid |-> $past(i_rx_done || i_tok_valid))
			else $error("handshake without cause");
	tx_len_a:
		assert property (o_hs_valid && o_hs != usb_ep_pkg::HS_TX_COUNT
			|-> o_tx_len == 4'h0) else $error("length without count");
	bad_ep_a:
		assert property (i_tok_valid && i_tok_ep > 3'h4 && !i_rx_done
			|=> !o_hs_valid) else $error("absent endpoint answered");
	bad_crc_a:
		assert property (i_rx_done && !i_rx_info.crc_ok |=> !o_hs_valid
			|| o_hs == usb_ep_pkg::HS_NONE) else $error("bad packet answered");
	intr_set_a:
		assert property (|(o_ep_intr & ~$past(o_ep_intr)) |->
			$past(i_rx_done || i_host_ack || i_tok_valid))
			else $error("interrupt set outside commit");
	intr_clr_a:
		assert property (|($past(o_ep_intr) & ~o_ep_intr) |-> $past(i_avs_write
			&& !o_avs_waitrequest && i_avs_address == usb_ep_pkg::REG_INTR))
			else $error("interrupt cleared without write");
endmodule // usb_ep_mode_lock_properties
bind usb_ep_mode_lock usb_ep_mode_lock_properties chk_u (
	.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
	.i_tok_valid(i_tok_valid), .i_tok_ep(i_tok_ep), .i_rx_done(i_rx_done),
	.i_rx_info(i_rx_info), .i_host_ack(i_host_ack), .o_hs_valid(o_hs_valid),
	.o_hs(o_hs), .o_tx_len(o_tx_len), .o_ep_intr(o_ep_intr));
`default_nettype wire
